// File: hdl/spc_pkg.sv
// spc_pkg: register map, field positions, reset values and divider helpers
// of the shift clock prescaler and status block.
// assumes an 8-bit special function register port on the core side.
package spc_pkg;

    localparam logic [7:0] ADDR_DIVIDER = 8'hd2;
    localparam logic [7:0] ADDR_STATUS = 8'hd3;
    localparam logic [7:0] ADDR_TX_DATA = 8'hd4;
    localparam logic [7:0] ADDR_RX_DATA = 8'hd5;

    localparam logic [7:0] DIVIDER_RESET = 8'h04;
    localparam logic [7:0] DIVIDER_WMASK = 8'hfc;
    localparam logic [7:0] STATUS_RESET = 8'h02;

    localparam int BIT_SEL_128 = 7;
    localparam int BIT_SEL_4 = 2;

    localparam int BIT_BUSY = 4;
    localparam int BIT_TX_END = 3;
    localparam int BIT_RX_OVERRUN = 2;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_RX_FULL = 0;

    localparam int HALF_W = 7;

    // half period in oscillator cycles for the largest selected divisor;
    // zero means no select bit is set and the shift clock stands still
    function automatic logic [HALF_W-1:0] spc_half_period(input logic [7:0] sel);
        logic [HALF_W-1:0] half;
        half = 7'h00;
        for (int b = BIT_SEL_4; b <= BIT_SEL_128; b++)
        begin
            if (sel[b])
            begin
                half = HALF_W'(1 << (b - 1));
            end
        end
        return half;
    endfunction : spc_half_period

endpackage : spc_pkg

// File: hdl/spc_div_if.sv
// spc_div_if: carries the divider selection to the prescaler and the shift
// clock back from it. assumes both ends share i_clk.
`timescale 1ns/1ns
`default_nettype none
interface spc_div_if;
    logic [7:0] sel;
    logic shift_clk;
    logic rise_tick;

    modport ctrl (output sel, input shift_clk, input rise_tick);
    modport div (input sel, output shift_clk, output rise_tick);
endinterface : spc_div_if
`default_nettype wire

// File: hdl/spc_prescaler.sv
// spc_prescaler: divides the oscillator clock by the selected power of two.
// assumes a synchronous active-low reset copy from the top.
`timescale 1ns/1ns
`default_nettype none
module spc_prescaler (
    input wire logic i_clk,
    input wire logic i_rst_n,
    spc_div_if.div div
);
    logic [spc_pkg::HALF_W-1:0] count;
    logic [spc_pkg::HALF_W-1:0] half;

    assign half = spc_pkg::spc_half_period(div.sel);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count <= 7'h00;
            div.shift_clk <= 1'b0;
            div.rise_tick <= 1'b0;
        end
        else if (half == 7'h00)
        begin
            // no select bit: park the clock low rather than guess a rate
            count <= 7'h00;
            div.shift_clk <= 1'b0;
            div.rise_tick <= 1'b0;
        end
        else if (count >= half - 7'h01)
        begin
            // >= so that a smaller divisor written mid-count takes effect at once
            count <= 7'h00;
            div.shift_clk <= ~div.shift_clk;
            div.rise_tick <= ~div.shift_clk;
        end
        else
        begin
            count <= count + 7'h01;
            div.rise_tick <= 1'b0;
        end
    end
endmodule : spc_prescaler
`default_nettype wire

// File: hdl/spc_top.sv
// spc_top: shift clock prescaler, data registers and status flags of the
// serial master. assumes the shift engine runs on i_clk and reports its
// events as one-cycle pulses; the core reaches registers by sfr strobes.
//
// Operation
// - six select bits divide oscillator by 128..4
// - divider register resets to 04h
// - status register resets to 02h
// - transmission end sets flag bit 3
// - status read clears transmission end flag
// - transmit data write clears empty flag
// - byte load into shifter sets empty flag
// - status read clears transmission end and overrun flags
// - interrupt only for enabled flag conditions
// - receive interrupt means receive register full
`timescale 1ns/1ns
`default_nettype none
module spc_top (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_tx_end_irq_en,
    input wire logic i_overrun_irq_en,
    input wire logic i_tx_empty_irq_en,
    input wire logic i_rx_full_irq_en,
    input wire logic i_xfer_active,
    input wire logic i_tx_load,
    input wire logic i_tx_end,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    output logic [7:0] o_tx_data,
    output logic o_tx_full,
    output logic o_serial_shift_clock,
    output logic o_shift_rise,
    output logic o_irq
);
    logic rst_meta;
    logic rst_n;
    logic [7:0] shift_clock_divider;
    logic [7:0] rx_data_reg;
    logic busy;
    logic tx_end_flag;
    logic rx_overrun_flag;
    logic tx_empty_flag;
    logic rx_full_flag;
    logic rd_status;
    logic rd_rx;
    logic wr_tx;
    logic [7:0] next_rdata;

    spc_div_if div_if ();

    spc_prescaler u_prescaler (
        .i_clk (i_clk),
        .i_rst_n (rst_n),
        .div (div_if.div)
    );

    assign div_if.sel = shift_clock_divider;
    assign rd_status = i_sfr_rd && (i_sfr_addr == spc_pkg::ADDR_STATUS);
    assign rd_rx = i_sfr_rd && (i_sfr_addr == spc_pkg::ADDR_RX_DATA);
    assign wr_tx = i_sfr_wr && (i_sfr_addr == spc_pkg::ADDR_TX_DATA);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_clock_divider <= spc_pkg::DIVIDER_RESET;
        end
        else if (i_sfr_wr && (i_sfr_addr == spc_pkg::ADDR_DIVIDER))
        begin
            // the two unused low bits stay zero
            shift_clock_divider <= i_sfr_wdata & spc_pkg::DIVIDER_WMASK;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_tx_data <= 8'h00;
        end
        else if (wr_tx)
        begin
            o_tx_data <= i_sfr_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_data_reg <= 8'h00;
        end
        else if (i_rx_valid)
        begin
            rx_data_reg <= i_rx_byte;
        end
    end

    // status reset value 02h is spread over the flag resets below
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= spc_pkg::STATUS_RESET[spc_pkg::BIT_BUSY];
        end
        else
        begin
            busy <= i_xfer_active;
        end
    end

    // in every flag a hardware set in the clearing cycle wins
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_end_flag <= spc_pkg::STATUS_RESET[spc_pkg::BIT_TX_END];
        end
        else if (i_tx_end)
        begin
            tx_end_flag <= 1'b1;
        end
        else if (rd_status)
        begin
            tx_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_overrun_flag <= spc_pkg::STATUS_RESET[spc_pkg::BIT_RX_OVERRUN];
        end
        else if (i_rx_valid && rx_full_flag && !rd_rx)
        begin
            rx_overrun_flag <= 1'b1;
        end
        else if (rd_status)
        begin
            rx_overrun_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_empty_flag <= spc_pkg::STATUS_RESET[spc_pkg::BIT_TX_EMPTY];
        end
        else if (i_tx_load)
        begin
            tx_empty_flag <= 1'b1;
        end
        else if (wr_tx)
        begin
            tx_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_full_flag <= spc_pkg::STATUS_RESET[spc_pkg::BIT_RX_FULL];
        end
        else if (i_rx_valid)
        begin
            rx_full_flag <= 1'b1;
        end
        else if (rd_rx)
        begin
            rx_full_flag <= 1'b0;
        end
    end

    always_comb
    begin
        case (i_sfr_addr)
            spc_pkg::ADDR_DIVIDER: next_rdata = shift_clock_divider;
            spc_pkg::ADDR_STATUS: next_rdata = {3'h0, busy, tx_end_flag, rx_overrun_flag,
                                                tx_empty_flag, rx_full_flag};
            spc_pkg::ADDR_TX_DATA: next_rdata = o_tx_data;
            spc_pkg::ADDR_RX_DATA: next_rdata = rx_data_reg;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_sfr_rdata <= 8'h00;
        end
        else if (i_sfr_rd)
        begin
            o_sfr_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= (tx_end_flag && i_tx_end_irq_en)
                || (rx_overrun_flag && i_overrun_irq_en)
                || (tx_empty_flag && i_tx_empty_irq_en)
                || (rx_full_flag && i_rx_full_irq_en);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_tx_full <= 1'b0;
            o_serial_shift_clock <= 1'b0;
            o_shift_rise <= 1'b0;
        end
        else
        begin
            // full is the inverse of the next value of the empty flag, so it changes in the same cycle as the flag
            o_tx_full <= !(i_tx_load || (tx_empty_flag && !wr_tx));
            o_serial_shift_clock <= div_if.shift_clk;
            o_shift_rise <= div_if.rise_tick;
        end
    end
endmodule : spc_top
`default_nettype wire

// File: testbench/spc_checker.sv
// spc_checker: port timing relations of the prescaler and status block.
// assumes single-cycle register strobes and same-clock engine pulses.
`timescale 1ns/1ns
`default_nettype none
module spc_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic i_tx_empty_irq_en,
    input wire logic i_xfer_active,
    input wire logic i_tx_load,
    input wire logic i_tx_end,
    input wire logic i_rx_valid,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_tx_full,
    input wire logic o_serial_shift_clock,
    input wire logic o_shift_rise,
    input wire logic o_irq
);
    logic [1:0] age;
    wire logic rs = i_sfr_rd && i_sfr_addr == 8'hd3;
    wire logic quiet = !i_tx_end && !i_rx_valid;
    // the internal reset copy lags release by two edges
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            age <= 2'd0;
        else if (age != 2'd3)
            age <= age + 2'd1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || age != 2'd3);
    property p_wr_full;
        i_sfr_wr && i_sfr_addr == 8'hd4 && !i_tx_load |=> o_tx_full;
    endproperty
    a_wr_full: assert property (p_wr_full)
        else $error("tx full not set by data write");
    property p_load;
        i_tx_load |=> !o_tx_full;
    endproperty
    a_load: assert property (p_load)
        else $error("tx empty not set by load");
    property p_te_set;
        i_tx_end ##1 rs |=> o_sfr_rdata[3];
    endproperty
    a_te_set: assert property (p_te_set)
        else $error("tx end flag not set");
    property p_rd_clr;
        (rs && quiet) ##1 quiet [*2] ##0 rs |=> o_sfr_rdata[3:2] == 2'b00;
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("status read did not clear flags");
    property p_busy;
        rs |=> o_sfr_rdata[4] == $past(i_xfer_active, 2);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy bit wrong");
    property p_rxf;
        i_rx_valid ##1 rs |=> o_sfr_rdata[0];
    endproperty
    a_rxf: assert property (p_rxf)
        else $error("rx full flag not set");
    property p_irq;
        !o_tx_full && i_tx_empty_irq_en |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled empty flag gave no irq");
    property p_sck;
        $rose(o_serial_shift_clock) |-> o_shift_rise;
    endproperty
    a_sck: assert property (p_sck)
        else $error("shift rise pulse missing");
    c_end: cover property (i_tx_end ##1 rs);
    c_ovr: cover property (rs ##1 o_sfr_rdata[2]);
    c_irq: cover property (o_irq);
endmodule : spc_checker
bind spc_top spc_checker i_spc_checker (.*);
`default_nettype wire

// File: testbench/spc_engine.sv
// spc_engine: shift engine model; takes a waiting tx byte, ends 16 cycles on.
// assumes the block's tx_full level; returns the inverted byte as rx.
`timescale 1ns/1ns
`default_nettype none
module spc_engine (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_full,
    input wire logic [7:0] i_tx_data,
    output logic o_busy,
    output logic o_load,
    output logic o_end,
    output logic o_rxv,
    output logic [7:0] o_rxb
);
    logic [4:0] cnt;
    wire logic take = !o_busy && !o_load && i_tx_full;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            {cnt, o_busy, o_load, o_end, o_rxv, o_rxb} <= '0;
        else
        begin
            o_load <= take;
            o_busy <= o_load || (o_busy && cnt != 5'd1);
            o_end <= o_busy && cnt == 5'd1;
            o_rxv <= o_busy && cnt == 5'd1;
            cnt <= o_busy ? cnt - 5'd1 : 5'd16;
            o_rxb <= take ? ~i_tx_data : o_rxb;
        end
    end
endmodule : spc_engine
`default_nettype wire

// File: testbench/testbench.sv
// testbench: drives registers and an engine model, checks by register reads and by the tx_full, irq and shift clock outputs.
// assumes a 50 ns clock; engine model on the far side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_clk = 0, i_rst_n = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, wd = 0, rdata, txd, rxb, v, n;
    logic [3:0] en = 0;
    logic full, sck, rise, irq, busy, ld, te, rxv;
    int error_cnt = 0, n_compared = 0;
    always #25 i_clk = ~i_clk;
    spc_top i_spc_top(.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_tx_end_irq_en(en[3]),
        .i_overrun_irq_en(en[2]), .i_tx_empty_irq_en(en[1]), .i_rx_full_irq_en(en[0]),
        .i_xfer_active(busy), .i_tx_load(ld), .i_tx_end(te), .i_rx_valid(rxv),
        .i_rx_byte(rxb), .o_tx_data(txd), .o_tx_full(full), .o_serial_shift_clock(sck),
        .o_shift_rise(rise), .o_irq(irq));
    spc_engine i_spc_engine(.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_full(full),
        .i_tx_data(txd), .o_busy(busy), .o_load(ld), .o_end(te), .o_rxv(rxv), .o_rxb(rxb));
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge i_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge i_clk);
    endtask : acc
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string s);
        acc(1'b0, a, 8'h00);
        chk(s, e, rdata);
    endtask : rchk
    // cycles from one shift rise pulse to the next, bounded
    task automatic tick(output logic [7:0] p);
        p = 8'h00;
        do
        begin
            @(posedge i_clk);
            #1 p++;
            if (p == 8'hff)
            begin
                error_cnt++;
                results();
            end
        end while (!rise);
        chk("shift_clock", 8'h01, {7'h00, sck});
    endtask : tick
    function automatic logic [7:0] divisor(input logic [7:0] s);
        divisor = 8'h00;
        for (int b = 2; b < 8; b++)
            if (s[b])
                divisor = 8'h01 << b;
    endfunction : divisor
    initial
    begin
        void'($urandom(32'h2850));
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk(8'hd2, 8'h04, "divider");
        rchk(8'hd3, 8'h02, "status");
        rchk(8'h40, 8'h00, "unmapped");
        for (int i = 0; i < 9; i++)
        begin
            v = (i < 6) ? (8'h07 << i) : (8'($urandom) | 8'h04);
            acc(1'b1, 8'hd2, v);
            rchk(8'hd2, v & 8'hfc, "divider_rb");
            repeat (3) tick(n);
            chk("period", divisor(v), n);
        end
        $display("test divider done");
        v = 8'($urandom);
        acc(1'b1, 8'hd4, v);
        chk("tx_full", 8'h01, {7'h00, full});
        repeat (3) @(posedge i_clk);
        rchk(8'hd3, 8'h12, "busy");
        repeat (25) @(posedge i_clk);
        for (int i = 0; i < 8; i++)
        begin
            // enables change on the edge, irq is looked at two edges later
            @(posedge i_clk);
            en <= (i < 4) ? (4'h1 << i) : 4'($urandom);
            repeat (2) @(posedge i_clk);
            #1 chk("irq", {7'h00, |(en & 4'hb)}, {7'h00, irq});
        end
        rchk(8'hd3, 8'h0b, "end_flags");
        rchk(8'hd3, 8'h03, "read_clear");
        rchk(8'hd5, ~v, "rx_data");
        rchk(8'hd4, v, "tx_data");
        rchk(8'hd3, 8'h02, "rx_clear");
        repeat (2)
        begin
            acc(1'b1, 8'hd4, 8'($urandom));
            repeat (25) @(posedge i_clk);
        end
        rchk(8'hd3, 8'h0f, "overrun");
        rchk(8'hd3, 8'h03, "overrun_clear");
        $display("test transfer done");
        // reset again with a random divider and a dirty receive register
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk(8'hd2, 8'h04, "divider_rst");
        rchk(8'hd3, 8'h02, "status_rst");
        rchk(8'hd5, 8'h00, "rx_data_rst");
        $display("test reset done");
        results();
    end
endmodule : testbench
`default_nettype wire
